/* design/mcu_interrupt_logic.sv */
// Interrupt logic: request flags, enable registers, global enable and vectoring to page 1.
// Assumes the core pulses its strobes for one clock and branches on takeOut.valid.
// Summary of operation
// - Eight sources: two pins, timers, converter, serial.
// - External 0 edge chosen by its control bits.
// - External 1 edge chosen by its control bits.
// - Each timer underflow raises its own request.
// - External 0 needs enable A bit 0; vector 0.
// - External 1 needs enable A bit 1; vector 2.
// - Timer 1 needs enable A bit 2; vector 4.
// - Timer 2 needs enable A bit 3; vector 6.
// - Timer 3 needs enable B bit 0; vector 8.
// - Disabled A sources do not interrupt; skip polls.
// - Disabled timer 3 does not interrupt; skip polls.
// - Accepting any interrupt clears global enable.
// - Enable acts after one more instruction.
// - Flags set always; cleared by take or skip.
// - Timer 4 needs enable B bit 1; vector A.
`timescale 1ns/1ns
`default_nettype none
module mcu_interrupt_logic
  import irq_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic       extIrq0Pin,
  input  wire logic       extIrq1Pin,
  input  wire logic [3:0] tmrUnderflow,
  input  wire logic       adcDone,
  input  wire logic       serialDone,
  input  wire nibble_wr_t enableRegAWr,
  input  wire nibble_wr_t enableRegBWr,
  input  wire nibble_wr_t ext0CtlWr,
  input  wire nibble_wr_t ext1CtlWr,
  input  wire logic       irqOnInstruction,
  input  wire logic       irqOffInstruction,
  input  wire logic       instrDone,
  input  wire logic       skipQuery,
  input  wire logic [2:0] skipSel,
  output logic            skipResult,
  output irq_take_t       takeOut,
  output logic [3:0]      irqEnableRegA,
  output logic [3:0]      irqEnableRegB,
  output logic [3:0]      ext0EdgeControlReg,
  output logic [3:0]      ext1EdgeControlReg,
  output logic            globalIrqEnableFlag,
  output logic [7:0]      pendingFlags
);

  logic [1:0]         extPins;        // Raw pin levels in source order.
  logic [1:0][3:0]    extCtl;         // Edge control registers in source order.
  logic [1:0]         extHit;         // Qualified pin pulses, index 0 and 1.
  logic [7:0]         setVec;         // This cycle's request events.
  logic [7:0]         enVec;          // Per-source enables from both registers.
  logic [7:0]         readyVec;       // Pending and enabled.
  logic [7:0]         clrTake;        // Flag cleared by acceptance.
  logic [7:0]         clrSkip;        // Flag cleared by a successful skip.
  logic [1:0]         holdoff_q;      // Instructions left before acceptance is allowed.
  logic               accept;         // An interrupt is accepted this cycle.
  logic [2:0]         winIdx;         // Index of the winning source.
  logic               skipHit;        // Skip condition met this cycle.

  // Both pins and their control registers gathered in source order for the detector loop.
  always_comb
  begin
    extPins = {extIrq1Pin, extIrq0Pin};
    extCtl  = {ext1EdgeControlReg, ext0EdgeControlReg};
  end

  // Pins go through a two-stage synchroniser before the waveform check.
  // One detector per pin, so both pins share the same qualification and the same latency.
  for (genvar p = 0; p < 2; p++)
  begin : g_pin
    pin_edge_detect u_edge (
      .clock   (clock),
      .srst    (srst),
      .pin     (extPins[p]),
      .edgeCtl (extCtl[p]),
      .hit     (extHit[p])
    );
  end

  // Request events in source order; timers feed straight in.
  always_comb
  begin
    setVec = {serialDone, adcDone, tmrUnderflow, extHit};
    enVec  = {irqEnableRegB, irqEnableRegA};
  end

  // A source may interrupt only with its own enable and the global flag set.
  always_comb
  begin
    readyVec = pendingFlags & enVec;
    accept   = globalIrqEnableFlag && (holdoff_q == 2'h0) && (readyVec != 8'h00);
  end

  // Fixed priority: the lowest index has the lowest vector address.
  always_comb
  begin
    winIdx = 3'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (readyVec[i])
      begin
        winIdx = 3'(i);
      end
    end
  end

  // Skip works only while the polled source is disabled.
  always_comb
  begin
    skipHit = skipQuery && pendingFlags[skipSel] && !enVec[skipSel];
    clrTake = 8'h00;
    clrSkip = 8'h00;
    if (accept)
    begin
      clrTake[winIdx] = 1'b1;
    end
    if (skipHit)
    begin
      clrSkip[skipSel] = 1'b1;
    end
  end

  // Request flags: set regardless of enables, and a set beats a clear in the same cycle.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      pendingFlags <= 8'h00;
    end
    else
    begin
      pendingFlags <= (pendingFlags & ~(clrTake | clrSkip)) | setVec;
    end
  end

  // Software-written registers.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      irqEnableRegA      <= ENABLE_RESET;
      irqEnableRegB      <= ENABLE_RESET;
      ext0EdgeControlReg <= EDGE_CTL_RESET;
      ext1EdgeControlReg <= EDGE_CTL_RESET;
    end
    else
    begin
      if (enableRegAWr.wr)
      begin
        irqEnableRegA <= enableRegAWr.data;
      end
      if (enableRegBWr.wr)
      begin
        irqEnableRegB <= enableRegBWr.data;
      end
      if (ext0CtlWr.wr)
      begin
        ext0EdgeControlReg <= ext0CtlWr.data;
      end
      if (ext1CtlWr.wr)
      begin
        ext1EdgeControlReg <= ext1CtlWr.data;
      end
    end
  end

  // Global enable: acceptance clears it; the enable strobe wins only when no acceptance.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      globalIrqEnableFlag <= 1'b0;
    end
    else if (accept)
    begin
      globalIrqEnableFlag <= 1'b0;
    end
    else if (irqOnInstruction)
    begin
      globalIrqEnableFlag <= 1'b1;
    end
    else if (irqOffInstruction)
    begin
      globalIrqEnableFlag <= 1'b0;
    end
  end

  // The enable strobe comes with its own completion; one later completion opens the gate.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      holdoff_q <= 2'h0;
    end
    else if (irqOnInstruction)
    begin
      holdoff_q <= ENABLE_HOLDOFF;
    end
    else if (instrDone && (holdoff_q != 2'h0))
    begin
      holdoff_q <= holdoff_q - 2'h1;
    end
  end

  // Vector is twice the source index inside page 1.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      takeOut    <= '0;
      skipResult <= 1'b0;
    end
    else
    begin
      takeOut.valid  <= accept;
      takeOut.vector <= accept ? 4'({1'b0, winIdx} * VECTOR_STEP) : takeOut.vector;
      skipResult     <= skipHit;
    end
  end

endmodule : mcu_interrupt_logic
`default_nettype wire

/* design/irq_pkg.sv */
// Shared constants and types for the interrupt logic of the small 4-bit controller.
// Assumes a single instruction clock and a synchronous, active-high system reset.
package irq_pkg;

  // Number of request sources and the width of the core's 4-bit registers.
  localparam int unsigned NUM_SRC   = 8;
  localparam int unsigned NIBBLE_W  = 4;
  localparam int unsigned SRC_IDX_W = 3;

  // Source positions in the pending and enable vectors.
  localparam logic [2:0] SRC_EXT0   = 3'h0;
  localparam logic [2:0] SRC_EXT1   = 3'h1;
  localparam logic [2:0] SRC_TMR1   = 3'h2;
  localparam logic [2:0] SRC_TMR2   = 3'h3;
  localparam logic [2:0] SRC_TMR3   = 3'h4;
  localparam logic [2:0] SRC_TMR4   = 3'h5;
  localparam logic [2:0] SRC_ADC    = 3'h6;
  localparam logic [2:0] SRC_SERIAL = 3'h7;

  // Reset values of the enable and edge control registers.
  localparam logic [3:0] ENABLE_RESET   = 4'h0;
  localparam logic [3:0] EDGE_CTL_RESET = 4'h0;

  // Field positions inside an edge control register.
  localparam int unsigned EDGE_BOTH_BIT   = 1;
  localparam int unsigned EDGE_RISING_BIT = 2;

  // Page 1 vector offsets step by two words per source.
  localparam logic [3:0] VECTOR_STEP = 4'h2;

  // Instructions that must still complete after the enable instruction.
  localparam logic [1:0] ENABLE_HOLDOFF = 2'h1;

  // One accepted interrupt handed to the core.
  typedef struct packed {
    logic       valid;   // One-cycle pulse: branch to the vector now.
    logic [3:0] vector;  // Address inside page 1.
  } irq_take_t;

  // A write to one of the 4-bit control registers.
  typedef struct packed {
    logic       wr;      // One-cycle write strobe.
    logic [3:0] data;    // Value to store.
  } nibble_wr_t;

endpackage : irq_pkg

/* design/pin_edge_detect.sv */
// Synchroniser and waveform qualifier for one external interrupt pin.
// Assumes the pin is asynchronous to the clock; the output is a one-cycle pulse.
`timescale 1ns/1ns
`default_nettype none
module pin_edge_detect
  import irq_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic       pin,
  input  wire logic [3:0] edgeCtl,
  output logic            hit
);

  logic syncA_q;  // First synchroniser stage, read only by the second.
  logic syncB_q;  // Second synchroniser stage.
  logic last_q;   // Previous synchronised level for edge detection.
  logic hit_d;    // Qualified edge before registering.

  // Two flip-flops bring the pin into the clock domain, then one more remembers the last level.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      syncA_q <= 1'b0;
      syncB_q <= 1'b0;
      last_q  <= 1'b0;
    end
    else
    begin
      syncA_q <= pin;
      syncB_q <= syncA_q;
      last_q  <= syncB_q;
    end
  end

  // Both edges when selected, otherwise the edge chosen by the polarity field.
  always_comb
  begin
    if (edgeCtl[EDGE_BOTH_BIT])
    begin
      hit_d = syncB_q ^ last_q;
    end
    else if (edgeCtl[EDGE_RISING_BIT])
    begin
      hit_d = syncB_q & ~last_q;
    end
    else
    begin
      hit_d = ~syncB_q & last_q;
    end
  end

  // Registered so that one pin transition gives exactly one pulse.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      hit <= 1'b0;
    end
    else
    begin
      hit <= hit_d;
    end
  end

endmodule : pin_edge_detect
`default_nettype wire

/* verification/irq_src_model.sv */
// Model of the pins, timers, converter and serial unit.
// Assumes the bench pulses fire for one clock per event.
`timescale 1ns/1ns
`default_nettype none
module irq_src_model
(
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic [7:0] fire,
  output logic      [1:0] pins,
  output logic      [5:0] pulses
);
  // Pins toggle per event, so either edge can be exercised; reset parks them low like the detectors.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      pins   <= 2'h0;
      pulses <= 6'h00;
    end
    else
    begin
      pins   <= pins ^ fire[1:0];
      pulses <= fire[7:2];
    end
  end
endmodule : irq_src_model
`default_nettype wire

/* verification/irq_asserts.sv */
// Port checker for the interrupt logic.
// Assumes one clock and the synchronous reset.
`timescale 1ns/1ns
`default_nettype none
module irq_asserts
  import irq_pkg::*;
(
  input wire logic       clock,
  input wire logic       srst,
  input wire logic [3:0] tmrUnderflow,
  input wire logic       adcDone,
  input wire nibble_wr_t enableRegAWr,
  input wire logic       irqOnInstruction,
  input wire logic       skipQuery,
  input wire logic [2:0] skipSel,
  input wire logic       skipResult,
  input wire irq_take_t  takeOut,
  input wire logic [3:0] irqEnableRegA,
  input wire logic [3:0] irqEnableRegB,
  input wire logic       globalIrqEnableFlag,
  input wire logic [7:0] pendingFlags
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  logic [7:0] penEn;    // Pending and enabled sources.
  logic [2:0] lowIdx_q; // Winner a cycle late.
  logic       skip_q;   // Skip answer a cycle late.
  assign penEn = pendingFlags & {irqEnableRegB, irqEnableRegA};
  // The last assignment in the loop wins, which picks the lowest index.
  always_ff @(posedge clock)
  begin
    lowIdx_q <= 3'h0;
    for (int k = 7; k >= 0; k--)
      if (penEn[k]) lowIdx_q <= k[2:0];
    skip_q <= !srst && skipQuery && pendingFlags[skipSel] && !penEn[skipSel];
  end
  sequence sOnStart;
    irqOnInstruction && !globalIrqEnableFlag;
  endsequence
  a_off_no_take: assert property (!globalIrqEnableFlag |=> !takeOut.valid)
    else $error("take while disabled");
  a_take_clears_gie: assert property (takeOut.valid |-> !globalIrqEnableFlag)
    else $error("enable kept");
  a_take_lowest_src: assert property (takeOut.valid |-> takeOut.vector == {lowIdx_q, 1'b0})
    else $error("wrong vector");
  a_skip_answer: assert property (skipResult == skip_q)
    else $error("skip answer");
  a_tmr_sets_flag: assert property (tmrUnderflow[0] |=> pendingFlags[2])
    else $error("timer flag");
  a_adc_sets_flag: assert property (adcDone |=> pendingFlags[6])
    else $error("adc flag");
  a_on_holdoff: assert property (sOnStart |=> !takeOut.valid [*2])
    else $error("early take");
  a_regA_write: assert property (enableRegAWr.wr |=> irqEnableRegA == $past(enableRegAWr.data))
    else $error("enable write");
endmodule : irq_asserts
bind mcu_interrupt_logic irq_asserts chk (.clock(clock), .srst(srst), .tmrUnderflow(tmrUnderflow),
  .adcDone(adcDone), .enableRegAWr(enableRegAWr), .irqOnInstruction(irqOnInstruction),
  .skipQuery(skipQuery), .skipSel(skipSel), .skipResult(skipResult), .takeOut(takeOut),
  .irqEnableRegA(irqEnableRegA), .irqEnableRegB(irqEnableRegB),
  .globalIrqEnableFlag(globalIrqEnableFlag), .pendingFlags(pendingFlags));
`default_nettype wire

/* verification/mcu_interrupt_logic_tb.sv */
// Self-checking bench for the interrupt logic.
// Assumes the source model and the bound checker.
`timescale 1ns/1ns
`default_nettype none
module mcu_interrupt_logic_tb
  import irq_pkg::*;
;
  logic clock, srst, on, off, done, q;
  logic [2:0] sel;
  logic [7:0] fire;
  logic [1:0] pins;
  logic [5:0] pulses;
  nibble_wr_t enA, enB, c0, c1;
  logic skipRes, gie;
  irq_take_t take;
  logic [3:0] rA, rB, r0, r1;
  logic [7:0] pend;
  logic [7:0] en;
  int errCount, cmpCount, j, pick;
  irq_src_model src (.clock(clock), .srst(srst), .fire(fire), .pins(pins), .pulses(pulses));
  mcu_interrupt_logic uut (.clock(clock), .srst(srst), .extIrq0Pin(pins[0]), .extIrq1Pin(pins[1]),
    .tmrUnderflow(pulses[3:0]), .adcDone(pulses[4]), .serialDone(pulses[5]), .enableRegAWr(enA),
    .enableRegBWr(enB), .ext0CtlWr(c0), .ext1CtlWr(c1), .irqOnInstruction(on),
    .irqOffInstruction(off), .instrDone(done), .skipQuery(q), .skipSel(sel), .skipResult(skipRes),
    .takeOut(take), .irqEnableRegA(rA), .irqEnableRegB(rB), .ext0EdgeControlReg(r0),
    .ext1EdgeControlReg(r1), .globalIrqEnableFlag(gie), .pendingFlags(pend));
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task cyc; @(posedge clock); endtask : cyc
  task chk(input logic [19:0] got, input logic [19:0] exp);
    cmpCount++;
    if (got !== exp)
    begin
      errCount++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task results;
    if (errCount == 0 && cmpCount > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results
  // Page 1 entry address of each source; the converter and serial entries keep the two-word step.
  function automatic logic [3:0] expVector(input int i);
    case (i)
      0: return 4'h0;
      1: return 4'h2;
      2: return 4'h4;
      3: return 4'h6;
      4: return 4'h8;
      5: return 4'ha;
      6: return 4'hc;
      default: return 4'he;
    endcase
  endfunction : expVector
  // Writes both enable registers; the strobe drops a cycle later and the value is read back.
  task wrEn(input logic [7:0] v);
    cyc; enA <= '{1'b1, v[3:0]}; enB <= '{1'b1, v[7:4]};
    cyc; enA.wr <= 1'b0; enB.wr <= 1'b0;
    @(negedge clock);
    chk({rB, rA}, v);
  endtask : wrEn
  task raise(input int i);
    cyc; fire <= 8'h1 << i;
    cyc; fire <= 8'h0;
    repeat (6) cyc;
  endtask : raise
  // Enable instruction, then one more completed instruction.
  task enableInstr;
    cyc; on <= 1'b1; done <= 1'b1;
    cyc; on <= 1'b0;
    cyc; done <= 1'b0;
  endtask : enableInstr
  task waitTake(input int i);
    logic got;
    got = 1'b0;
    repeat (8)
    begin
      @(negedge clock);
      if (take.valid === 1'b1) begin got = 1'b1; break; end
    end
    chk({got, take.vector, gie, pend[i]}, {1'b1, expVector(i), 2'h0});
  endtask : waitTake
  // Polls one source; the answer and the flag left behind are both compared.
  task skip(input int i, input logic exp, input logic expPend);
    cyc; q <= 1'b1; sel <= 3'(i);
    cyc; q <= 1'b0;
    @(negedge clock);
    chk({skipRes, pend[i]}, {exp, expPend});
  endtask : skip
  initial
  begin
    {srst, on, off, done, q, sel, fire} = '0;
    {enA, enB, c0, c1} = '0;
    void'($urandom(32'h7e3f));
    srst = 1'b1;
    repeat (12) cyc;
    srst <= 1'b0;
    @(negedge clock);
    chk({rA, rB, r0, r1, gie}, 20'h0);
    chk({pend, take.valid, skipRes}, 20'h0);
    cyc; c0 <= '{1'b1, 4'h2}; c1 <= '{1'b1, 4'h2};
    cyc; c0.wr <= 1'b0; c1.wr <= 1'b0;
    @(negedge clock);
    chk({r1, r0}, 20'h22);
    // Sources 0 to 5 each reach their own vector.
    for (int i = 0; i < 6; i++)
    begin
      wrEn(8'h1 << i);
      raise(i);
      enableInstr;
      waitTake(i);
    end
    // Random enables and sources: an enabled source is taken, a disabled one is polled.
    for (int n = 0; n < 16; n++)
    begin
      en = 8'($urandom);
      pick = $urandom % 8;
      wrEn(en);
      raise(pick);
      if (en[pick])
      begin
        enableInstr;
        waitTake(pick);
      end
      else
      begin
        skip(pick, 1'b1, 1'b0);
      end
    end
    // Disabled sources are polled instead.
    wrEn(8'h0);
    for (int i = 0; i < 8; i++)
    begin
      raise(i);
      skip(i, 1'b1, 1'b0);
    end
    enableInstr;
    @(negedge clock);
    chk(gie, 1'b1);
    cyc; off <= 1'b1;
    cyc; off <= 1'b0;
    @(negedge clock);
    chk(gie, 1'b0);
    // An enabled source refuses the skip; the lowest source wins.
    wrEn(8'hff);
    raise(3);
    skip(3, 1'b0, 1'b1);
    j = $urandom % 3;
    raise(j);
    enableInstr;
    waitTake(j);
    chk(pend[3], 1'b1);
    enableInstr;
    waitTake(3);
    // Rising edges only on pin 0, falling only on pin 1: every toggle is polled on its own.
    wrEn(8'h0);
    cyc; c0 <= '{1'b1, 4'h4}; c1 <= '{1'b1, 4'h0};
    cyc; c0.wr <= 1'b0; c1.wr <= 1'b0;
    for (int k = 0; k < 2; k++)
    begin
      raise(0);
      skip(0, pins[0], 1'b0);
      raise(1);
      skip(1, !pins[1], 1'b0);
    end
    // A reset in mid-run with a request pending and a control register written.
    raise(7);
    cyc;
    srst <= 1'b1;
    cyc;
    cyc;
    srst <= 1'b0;
    @(negedge clock);
    chk({rA, rB, r0, r1, gie}, 20'h0);
    chk({pend, take.valid, skipRes}, 20'h0);
    results;
  end
  // Watchdog: the tests need well under a thousand cycles.
  initial
  begin
    repeat (3000) @(posedge clock);
    errCount++;
    results;
  end
endmodule : mcu_interrupt_logic_tb
`default_nettype wire
